//--- bench/cascaded_irq_ctrl_programming_bench.sv
`timescale 1ns/1ps
module cascaded_irq_ctrl_programming_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cpu_reset_i = 1'b0;
  logic ce = 1'b1;
  logic [15:0] irq_i = 16'h0000;
  logic [15:0] io_addr;
  logic io_wr, io_rd, inta, io_rvalid, int_o, ack_valid;
  logic [7:0] io_wdata, io_rdata, ack_vec;
  logic [3:0] ack_irq;
  int errors = 0;
  int compares = 0;

  always #2.5 clk_i = ~clk_i;

  circ_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .cpu_reset_i(cpu_reset_i), .inta_i(inta), .int_o(int_o),
    .ack_valid_o(ack_valid), .ack_irq_o(ack_irq), .ack_vector_o(ack_vec), .irq_i(irq_i));

  circ_host host (.clk_i(clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_wdata_o(io_wdata), .inta_o(inta), .io_rdata_i(io_rdata), .io_rvalid_i(io_rvalid));

  // ==========================================================================
  // Shared checks.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01, "read valid");
    chk(d, exp, "read data");
  endtask

  task automatic ackchk(input logic [3:0] line, input logic [7:0] vec);
    host.ack();
    chk({7'h00, ack_valid}, 8'h01, "ack valid");
    chk({4'h0, ack_irq}, {4'h0, line}, "ack line");
    chk(ack_vec, vec, "ack vector");
  endtask

  // Request lines change off the falling edge; the request path is 16 cycles at most.
  task automatic irq_wait(input logic [15:0] v, input logic exp);
    @(negedge clk_i);
    irq_i = v;
    repeat (16) @(negedge clk_i);
    chk({7'h00, int_o}, {7'h00, exp}, "interrupt out");
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    rdchk(16'h0021, 8'h00);
    rdchk(16'h00A1, 8'h00);
    rdchk(16'h0030, 8'h00);
  endtask

  task automatic t_init();
    host.init(16'h0020, 8'h08, 8'h04, 8'h01);
    host.init(16'h00A0, 8'h70, 8'h02, 8'h01);
    host.wr(16'h0021, 8'hA5);
    rdchk(16'h0021, 8'hA5);
    host.init(16'h0020, 8'h08, 8'h04, 8'h01);
    rdchk(16'h0021, 8'h00);
    host.wr(16'h0021, 8'h5A);
    rdchk(16'h0021, 8'h5A);
    host.wr(16'h0021, 8'h00);
    // A write while the clock enable is low must leave the mask alone.
    @(negedge clk_i);
    ce = 1'b0;
    host.wr(16'h0021, 8'hFF);
    @(negedge clk_i);
    ce = 1'b1;
    rdchk(16'h0021, 8'h00);
  endtask

  task automatic t_mask();
    host.wr(16'h0021, 8'h20);
    irq_wait(16'h0020, 1'b0);
    host.wr(16'h0021, 8'h22);
    irq_wait(16'h0028, 1'b1);
    ackchk(4'h3, 8'h0B);
    irq_wait(16'h0000, 1'b0);
    host.wr(16'h0020, 8'h20);
    host.wr(16'h0021, 8'h00);
  endtask

  task automatic t_codes();
    irq_wait(16'h0010, 1'b1);
    ackchk(4'h4, 8'h0C);
    host.wr(16'h0020, 8'h0B);
    rdchk(16'h0020, 8'h10);
    host.wr(16'h0020, 8'h40);
    host.wr(16'h0020, 8'h62);
    rdchk(16'h0020, 8'h10);
    host.wr(16'h0020, 8'h64);
    rdchk(16'h0020, 8'h00);
    irq_wait(16'h0000, 1'b0);
    host.wr(16'h0020, 8'hC4);
    irq_wait(16'h0048, 1'b1);
    ackchk(4'h6, 8'h0E);
    host.wr(16'h0020, 8'hE6);
    ackchk(4'h3, 8'h0B);
    host.wr(16'h0020, 8'hA0);
    rdchk(16'h0020, 8'h00);
    irq_wait(16'h0000, 1'b0);
    @(negedge clk_i);
    cpu_reset_i = 1'b1;
    @(negedge clk_i);
    cpu_reset_i = 1'b0;
    irq_wait(16'h0048, 1'b1);
    ackchk(4'h3, 8'h0B);
    host.wr(16'h0020, 8'h20);
    ackchk(4'h6, 8'h0E);
    host.wr(16'h0020, 8'h20);
    irq_wait(16'h0000, 1'b0);
  endtask

  task automatic t_auto_end();
    host.init(16'h0020, 8'h08, 8'h04, 8'h03);
    host.wr(16'h0020, 8'h80);
    irq_wait(16'h0002, 1'b1);
    rdchk(16'h0020, 8'h02);
    ackchk(4'h1, 8'h09);
    host.wr(16'h0020, 8'h0B);
    rdchk(16'h0020, 8'h00);
    host.wr(16'h0020, 8'h00);
    // Rotation moved line 1 to the bottom, so line 6 beats line 0.
    irq_wait(16'h0041, 1'b1);
    ackchk(4'h6, 8'h0E);
    // Rotation is off now, so line 3 still beats line 1.
    irq_wait(16'h004B, 1'b1);
    ackchk(4'h3, 8'h0B);
    ackchk(4'h0, 8'h08);
    ackchk(4'h1, 8'h09);
    irq_wait(16'h0000, 1'b0);
    host.init(16'h0020, 8'h08, 8'h04, 8'h01);
  endtask

  task automatic t_slave();
    irq_wait(16'h0800, 1'b1);
    ackchk(4'hB, 8'h73);
    host.wr(16'h00A0, 8'h20);
    host.wr(16'h0020, 8'h20);
    irq_wait(16'h0000, 1'b0);
    host.wr(16'h0021, 8'h04);
    irq_wait(16'h0200, 1'b0);
    rdchk(16'h0021, 8'h04);
  endtask

  // ==========================================================================
  // Verdict and run control.
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_init();
    t_mask();
    t_codes();
    t_auto_end();
    t_slave();
    summarize();
  end
endmodule

//--- bench/circ_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host model: issues port cycles and acknowledge pulses off the falling edge.
module circ_host (
  // Clock.
  input wire logic clk_i,
  // Port cycles towards the controller.
  output logic [15:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o,
  output logic inta_o,
  // Answers from the controller.
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i
);
  initial begin
    io_addr_o = 16'hFFFF;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'hFF;
    inta_o = 1'b0;
  end

  // A released bus shows the inverse of its last value, never a stale copy.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(negedge clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    ok = io_rvalid_i;
    d = io_rdata_i;
  endtask

  task automatic ack();
    @(negedge clk_i);
    inta_o = 1'b1;
    @(negedge clk_i);
    inta_o = 1'b0;
  endtask

  // Start word, then exactly three data-port words in order.
  task automatic init(input logic [15:0] base, input logic [7:0] vec,
                      input logic [7:0] casc, input logic [7:0] mode);
    wr(base, 8'h11);
    wr(base + 16'h0001, vec);
    wr(base + 16'h0001, casc);
    wr(base + 16'h0001, mode);
  endtask
endmodule

//--- verilog/circ_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Base write with bit 4 set starts init; three data-port writes follow.
// - Init start clears mask, special mask mode, selects request readback.
// - Master cascade word marks which master line carries the slave.
// - Master mode bit 4 selects special fully nested operation; the slave ignores it.
// - Mode bit 1 selects automatic end of interrupt, else explicit command.
// - Mask bit 1 masks its line, 0 unmasks; mask resets to zero.
// - A masked line never sets its pending request bit.
// - Outside special mask mode, masking one line leaves all other lines unaffected, except master line 2, which blocks every slave line.
// - Data-port read returns the mask directly.
// - Master mask bit 2 blocks every slave request.
// - Reset or init restores fully nested priority, rotation off.
// - Codes 001, 011, 101 give non-specific, specific, rotating end.
// - Code 100 enables, 000 disables automatic-end rotation; 010 nothing.
// - Code 111 ends and rotates selected level; 110 sets it lowest.
// - Base write with bits 4:3 at 00 is the rotate/end command.
// - Level field selects level when bit 6 set, else ignored.
// - Base write with bits 4:3 at 01 is the readback control word.
module circ_ctrl (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Host I/O port access.
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // Processor reset and acknowledge.
  input wire logic cpu_reset_i,
  input wire logic inta_i,
  output logic int_o,
  output logic ack_valid_o,
  output logic [3:0] ack_irq_o,
  output logic [7:0] ack_vector_o,
  // Request pins, master on 7:0 and slave on 15:8.
  input wire logic [15:0] irq_i
);

  // ==========================================================================
  // Per-controller state, index 0 is the master and 1 the slave.
  logic [7:0] mask_q [2];
  logic [7:0] irr_q [2];
  logic [7:0] isr_q [2];
  logic [7:0] casc_q [2];
  logic [7:0] mode_q [2];
  logic [7:0] prev_q [2];
  logic [4:0] vbase_q [2];
  logic [2:0] lowest_q [2];
  circ_pkg::circ_init_t state_q [2];
  logic [1:0] rot_auto_end_enable_q;
  logic [1:0] rd_isr_q;
  logic [1:0] smm_q;
  logic slave_int_q;
  logic [7:0] wdata_hist_q;

  logic [15:0] irq_s;
  logic [7:0] line_in [2];
  logic [7:0] take_vec [2];
  logic [7:0] eoi_vec [2];
  logic [7:0] rd_mux [2];
  logic [1:0] hit_base, hit_data, wr_init, wr_cmd2;
  logic [1:0] wr_cmd3, wr_data, grant, svc_hit;
  logic [2:0] glvl [2];
  logic [2:0] svc_lvl [2];
  logic [2:0] cmd;
  logic [2:0] lvl;
  logic m_ack, casc_ack, s_ack;

  circ_sync #(
    .WIDTH(16)
  ) u_irq_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i(irq_i),
    .q_o(irq_s)
  );

  // ==========================================================================
  // Address and word decode.
  assign hit_base[0] = io_addr_i == circ_pkg::PORT_MASTER_BASE;
  assign hit_base[1] = io_addr_i == circ_pkg::PORT_SLAVE_BASE;
  assign hit_data[0] = io_addr_i == circ_pkg::PORT_MASTER_DATA;
  assign hit_data[1] = io_addr_i == circ_pkg::PORT_SLAVE_DATA;
  assign cmd = io_wdata_i[circ_pkg::CMD_HI:circ_pkg::CMD_LO];
  assign lvl = io_wdata_i[circ_pkg::LVL_HI:circ_pkg::LVL_LO];

  // The slave output stands in for master line 2.
  assign line_in[0] = {irq_s[7:3], slave_int_q, irq_s[1:0]};
  assign line_in[1] = irq_s[15:8];

  // ==========================================================================
  // Acknowledge: the master picks a level, the slave joins on a cascade line.
  assign m_ack = inta_i && grant[0];
  assign casc_ack = m_ack && casc_q[0][glvl[0]];
  assign s_ack = casc_ack && grant[1] && (casc_q[1][2:0] == glvl[0]);
  assign take_vec[0] = m_ack ? (circ_pkg::LINE_ONE << glvl[0]) : '0;
  assign take_vec[1] = s_ack ? (circ_pkg::LINE_ONE << glvl[1]) : '0;

  for (genvar c = 0; c < 2; c++) begin : gen_ctl
    logic eoi_ns;
    logic eoi_sp;
    logic rot_eoi;
    logic auto_end_enable;
    logic [2:0] clr_lvl;
    logic [7:0] blk;
    logic [7:0] self_ok;

    assign wr_init[c] = io_wr_i && hit_base[c] && io_wdata_i[circ_pkg::SEL_INIT_BIT];
    assign wr_cmd2[c] = io_wr_i && hit_base[c]
      && (io_wdata_i[circ_pkg::SEL_HI:circ_pkg::SEL_LO] == circ_pkg::SEL_ROT_EOI);
    assign wr_cmd3[c] = io_wr_i && hit_base[c]
      && (io_wdata_i[circ_pkg::SEL_HI:circ_pkg::SEL_LO] == circ_pkg::SEL_READBACK);
    assign wr_data[c] = io_wr_i && hit_data[c];

    // Specific codes carry bit 6, so the level field only counts then.
    assign eoi_ns = wr_cmd2[c] && (cmd == circ_pkg::CMD_NS_EOI || cmd == circ_pkg::CMD_ROT_NS_EOI);
    assign eoi_sp = wr_cmd2[c] && (cmd == circ_pkg::CMD_S_EOI || cmd == circ_pkg::CMD_ROT_S_EOI);
    assign clr_lvl = eoi_sp ? lvl : svc_lvl[c];
    assign eoi_vec[c] = (eoi_sp || (eoi_ns && svc_hit[c])) ? (circ_pkg::LINE_ONE << clr_lvl) : '0;
    assign rot_eoi = wr_cmd2[c] && ((cmd == circ_pkg::CMD_ROT_NS_EOI && svc_hit[c])
      || cmd == circ_pkg::CMD_ROT_S_EOI);
    assign auto_end_enable = mode_q[c][circ_pkg::MODE_AUTO_END_ENABLE_BIT];

    // Special mask mode lets masked in-service levels stop blocking.
    assign blk = isr_q[c] & ~(smm_q[c] ? mask_q[c] : '0);
    assign self_ok = (c == 0 && mode_q[c][circ_pkg::MODE_SPECIAL_NESTED_ENABLE_BIT]) ? casc_q[c] : '0;
    assign rd_mux[c] = hit_data[c] ? mask_q[c] : (rd_isr_q[c] ? isr_q[c] : irr_q[c]);

    circ_prio u_prio (
      .req_i(irr_q[c] & ~mask_q[c]),
      .blk_i(blk),
      .isr_i(isr_q[c]),
      .self_ok_i(self_ok),
      .lowest_i(lowest_q[c]),
      .grant_o(grant[c]),
      .grant_lvl_o(glvl[c]),
      .svc_hit_o(svc_hit[c]),
      .svc_lvl_o(svc_lvl[c])
    );

    // Requests latch on a rising line; a new edge wins over the clearing ack.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        prev_q[c] <= '0;
        irr_q[c] <= '0;
        isr_q[c] <= '0;
      end else if (ce_i) begin
        prev_q[c] <= line_in[c];
        irr_q[c] <= (irr_q[c] & ~take_vec[c]) | (line_in[c] & ~prev_q[c] & ~mask_q[c]);
        isr_q[c] <= (isr_q[c] & ~eoi_vec[c]) | (auto_end_enable ? '0 : take_vec[c]);
      end
    end

    // Initialization walk and data-port routing.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        state_q[c] <= circ_pkg::CIRC_READY;
        mask_q[c] <= circ_pkg::MASK_RESET;
        vbase_q[c] <= circ_pkg::VBASE_RESET;
        casc_q[c] <= circ_pkg::CASC_RESET;
        mode_q[c] <= circ_pkg::MODE_RESET;
      end else if (ce_i) begin
        if (wr_init[c]) begin
          state_q[c] <= circ_pkg::CIRC_WAIT_VEC;
          mask_q[c] <= circ_pkg::MASK_RESET;
        end else if (wr_data[c]) begin
          case (state_q[c])
            circ_pkg::CIRC_WAIT_VEC: begin
              vbase_q[c] <= io_wdata_i[circ_pkg::VBASE_HI:circ_pkg::VBASE_LO];
              state_q[c] <= circ_pkg::CIRC_WAIT_CASC;
            end
            circ_pkg::CIRC_WAIT_CASC: begin
              casc_q[c] <= io_wdata_i;
              state_q[c] <= circ_pkg::CIRC_WAIT_MODE;
            end
            circ_pkg::CIRC_WAIT_MODE: begin
              mode_q[c] <= io_wdata_i;
              state_q[c] <= circ_pkg::CIRC_READY;
            end
            circ_pkg::CIRC_READY: begin
              mask_q[c] <= io_wdata_i;
            end
            default: begin
              state_q[c] <= circ_pkg::CIRC_READY;
            end
          endcase
        end
      end
    end

    // Priority order, rotation and readback selection.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        lowest_q[c] <= circ_pkg::LOWEST_RESET;
        rot_auto_end_enable_q[c] <= 1'b0;
        rd_isr_q[c] <= 1'b0;
        smm_q[c] <= 1'b0;
      end else if (ce_i) begin
        if (cpu_reset_i || wr_init[c]) begin
          lowest_q[c] <= circ_pkg::LOWEST_RESET;
          rot_auto_end_enable_q[c] <= 1'b0;
          if (wr_init[c]) begin
            rd_isr_q[c] <= 1'b0;
            smm_q[c] <= 1'b0;
          end
        end else if (wr_cmd2[c]) begin
          if (cmd == circ_pkg::CMD_AUTO_END_ENABLE_ROT_SET) begin
            rot_auto_end_enable_q[c] <= 1'b1;
          end else if (cmd == circ_pkg::CMD_AUTO_END_ENABLE_ROT_CLR) begin
            rot_auto_end_enable_q[c] <= 1'b0;
          end
          if (cmd == circ_pkg::CMD_SET_PRIO) begin
            lowest_q[c] <= lvl;
          end else if (rot_eoi) begin
            lowest_q[c] <= clr_lvl;
          end
        end else if (wr_cmd3[c]) begin
          if (io_wdata_i[circ_pkg::RB_ACT_BIT]) begin
            rd_isr_q[c] <= io_wdata_i[circ_pkg::RB_ISR_BIT];
          end
          if (io_wdata_i[circ_pkg::SMM_EN_BIT]) begin
            smm_q[c] <= io_wdata_i[circ_pkg::SMM_BIT];
          end
        end else if (auto_end_enable && rot_auto_end_enable_q[c] && take_vec[c] != '0) begin
          lowest_q[c] <= glvl[c];
        end
      end
    end

    // ========================================================================
    // Checks.
    sequence s_init_start;
      ce_i && wr_init[c];
    endsequence
    sequence s_vec_word;
      ce_i && wr_data[c] && !wr_init[c] && state_q[c] == circ_pkg::CIRC_WAIT_VEC;
    endsequence
    sequence s_mode_word;
      ce_i && wr_data[c] && !wr_init[c] && state_q[c] == circ_pkg::CIRC_WAIT_MODE;
    endsequence
    property p_init_clears;
      @(posedge clk_i) disable iff (!rst_b_i)
        s_init_start |=> mask_q[c] == circ_pkg::MASK_RESET && !rd_isr_q[c] && !smm_q[c];
    endproperty
    a_init_clears: assert property (p_init_clears) else $error("init left mask set");
    property p_init_walk;
      @(posedge clk_i) disable iff (!rst_b_i)
        s_vec_word |=> state_q[c] == circ_pkg::CIRC_WAIT_CASC
          && vbase_q[c] == wdata_hist_q[circ_pkg::VBASE_HI:circ_pkg::VBASE_LO];
    endproperty
    a_init_walk: assert property (p_init_walk) else $error("vector word not taken");
    property p_mode_done;
      @(posedge clk_i) disable iff (!rst_b_i)
        s_mode_word |=> state_q[c] == circ_pkg::CIRC_READY && mode_q[c] == wdata_hist_q;
    endproperty
    a_mode_done: assert property (p_mode_done) else $error("mode word left init open");
    property p_mask_write;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i && wr_data[c] && state_q[c] == circ_pkg::CIRC_READY |=> mask_q[c] == wdata_hist_q;
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");
    property p_masked_quiet;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i |=> (irr_q[c] & ~$past(irr_q[c]) & $past(mask_q[c])) == '0;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked line pended");
    property p_read_mask;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i && io_rd_i && hit_data[c] |=> io_rvalid_o && io_rdata_o == $past(mask_q[c]);
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("mask readback wrong");
    property p_set_prio;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i && !cpu_reset_i && wr_cmd2[c] && cmd == circ_pkg::CMD_SET_PRIO
          |=> lowest_q[c] == wdata_hist_q[circ_pkg::LVL_HI:circ_pkg::LVL_LO];
    endproperty
    a_set_prio: assert property (p_set_prio) else $error("set priority ignored");
    property p_auto_end_enable_rot;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i && !cpu_reset_i && wr_cmd2[c]
          && (cmd == circ_pkg::CMD_AUTO_END_ENABLE_ROT_SET || cmd == circ_pkg::CMD_AUTO_END_ENABLE_ROT_CLR)
          |=> rot_auto_end_enable_q[c] == wdata_hist_q[circ_pkg::CMD_HI];
    endproperty
    a_auto_end_enable_rot: assert property (p_auto_end_enable_rot) else $error("auto-end rotation not updated");
    property p_nested_reset;
      @(posedge clk_i) disable iff (!rst_b_i)
        ce_i && cpu_reset_i |=> lowest_q[c] == circ_pkg::LOWEST_RESET && !rot_auto_end_enable_q[c];
    endproperty
    a_nested_reset: assert property (p_nested_reset) else $error("order not restored");
  end

  // ==========================================================================
  // Host readback and processor outputs, all registered.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      io_rdata_o <= circ_pkg::RDATA_NONE;
      io_rvalid_o <= 1'b0;
      slave_int_q <= 1'b0;
      int_o <= 1'b0;
      ack_valid_o <= 1'b0;
      ack_irq_o <= '0;
      ack_vector_o <= '0;
      wdata_hist_q <= '0;
    end else if (ce_i) begin
      io_rvalid_o <= io_rd_i;
      io_rdata_o <= (hit_base[0] || hit_data[0]) ? rd_mux[0] :
        ((hit_base[1] || hit_data[1]) ? rd_mux[1] : circ_pkg::RDATA_NONE);
      slave_int_q <= grant[1];
      int_o <= grant[0];
      ack_valid_o <= m_ack;
      ack_irq_o <= s_ack ? {1'b1, glvl[1]} : {1'b0, glvl[0]};
      ack_vector_o <= s_ack ? {vbase_q[1], glvl[1]} : {vbase_q[0], glvl[0]};
      wdata_hist_q <= io_wdata_i;
    end
  end

  property p_casc_block;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && mask_q[0][circ_pkg::CASC_LINE] |=> !$rose(irr_q[0][circ_pkg::CASC_LINE]);
  endproperty
  a_casc_block: assert property (p_casc_block) else $error("masked cascade line pended");

endmodule

//--- verilog/circ_pkg.sv
package circ_pkg;

  // ==========================================================================
  // Port map of the two controllers.
  localparam logic [15:0] PORT_MASTER_BASE = 16'h0020;
  localparam logic [15:0] PORT_MASTER_DATA = 16'h0021;
  localparam logic [15:0] PORT_SLAVE_BASE = 16'h00A0;
  localparam logic [15:0] PORT_SLAVE_DATA = 16'h00A1;

  // ==========================================================================
  // Field positions of the base-port and data-port words.
  localparam int unsigned SEL_INIT_BIT = 4;
  localparam int unsigned SEL_HI = 4;
  localparam int unsigned SEL_LO = 3;
  localparam int unsigned CMD_HI = 7;
  localparam int unsigned CMD_LO = 5;
  localparam int unsigned LVL_HI = 2;
  localparam int unsigned LVL_LO = 0;
  localparam int unsigned VBASE_HI = 7;
  localparam int unsigned VBASE_LO = 3;
  localparam int unsigned RB_ACT_BIT = 1;
  localparam int unsigned RB_ISR_BIT = 0;
  localparam int unsigned SMM_EN_BIT = 5;
  localparam int unsigned SMM_BIT = 6;
  localparam int unsigned MODE_AUTO_END_ENABLE_BIT = 1;
  localparam int unsigned MODE_SPECIAL_NESTED_ENABLE_BIT = 4;
  localparam int unsigned CASC_LINE = 2;

  localparam logic [1:0] SEL_ROT_EOI = 2'h0;
  localparam logic [1:0] SEL_READBACK = 2'h1;

  // ==========================================================================
  // Rotate and end-of-interrupt codes.
  localparam logic [2:0] CMD_AUTO_END_ENABLE_ROT_CLR = 3'h0;
  localparam logic [2:0] CMD_NS_EOI = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h2;
  localparam logic [2:0] CMD_S_EOI = 3'h3;
  localparam logic [2:0] CMD_AUTO_END_ENABLE_ROT_SET = 3'h4;
  localparam logic [2:0] CMD_ROT_NS_EOI = 3'h5;
  localparam logic [2:0] CMD_SET_PRIO = 3'h6;
  localparam logic [2:0] CMD_ROT_S_EOI = 3'h7;

  // ==========================================================================
  // Reset values and small constants.
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] CASC_RESET = 8'h00;
  localparam logic [7:0] LINE_ONE = 8'h01;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic [4:0] VBASE_RESET = 5'h00;
  localparam logic [2:0] LOWEST_RESET = 3'h7;
  localparam logic [2:0] PRIO_STEP = 3'h1;
  localparam logic [3:0] POS_NONE = 4'h8;

  typedef enum logic [1:0] {
    CIRC_READY = 2'h0,
    CIRC_WAIT_VEC = 2'h1,
    CIRC_WAIT_CASC = 2'h3,
    CIRC_WAIT_MODE = 2'h2
  } circ_init_t;

endpackage

//--- verilog/circ_prio.sv
`timescale 1ns/1ps
module circ_prio (
  // Request, blocking and service vectors.
  input wire logic [7:0] req_i,
  input wire logic [7:0] blk_i,
  input wire logic [7:0] isr_i,
  input wire logic [7:0] self_ok_i,
  input wire logic [2:0] lowest_i,
  // Resolved levels.
  output logic grant_o,
  output logic [2:0] grant_lvl_o,
  output logic svc_hit_o,
  output logic [2:0] svc_lvl_o
);

  // Position 0 is the level just above the lowest-priority level.
  function automatic logic [3:0] first_pos(input logic [7:0] vec, input logic [2:0] lowest);
    logic [3:0] pos;
    logic [2:0] lvl;
    pos = circ_pkg::POS_NONE;
    for (int p = 7; p >= 0; p--) begin
      lvl = lowest + 3'(p) + circ_pkg::PRIO_STEP;
      if (vec[lvl]) begin
        pos = 4'(p);
      end
    end
    return pos;
  endfunction

  logic [3:0] req_pos;
  logic [3:0] blk_pos;
  logic [3:0] svc_pos;

  // A level in service lets its own line through only where self_ok allows it.
  assign req_pos = first_pos(req_i, lowest_i);
  assign blk_pos = first_pos(blk_i & ~(req_i & self_ok_i), lowest_i);
  assign svc_pos = first_pos(isr_i, lowest_i);
  assign grant_o = (req_pos != circ_pkg::POS_NONE) && (req_pos < blk_pos);
  assign grant_lvl_o = lowest_i + req_pos[2:0] + circ_pkg::PRIO_STEP;
  assign svc_hit_o = svc_pos != circ_pkg::POS_NONE;
  assign svc_lvl_o = lowest_i + svc_pos[2:0] + circ_pkg::PRIO_STEP;

endmodule

//--- verilog/circ_sync.sv
`timescale 1ns/1ps
module circ_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule
